// >>> rtl/pwc_pkg.sv
// Constants and types shared by the primary word control decoder.
// Assumes a 100 MHz master clock and an APB master with 32-bit data.

package pwc_pkg;

    // ****************************************
    // Clock and frame
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int FRAME_BITS = 16;
    localparam int DAC_LSB = 2;
    localparam logic [4:0] BIT_CNT_INIT = 5'h10;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STEP = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_ADC = 8'h0C;
    localparam logic [7:0] OFS_DAC = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_EN = 1'b0;
    localparam logic [15:0] RST_PERIOD = 16'h0400;
    localparam logic [15:0] RST_ADC = 16'h0000;

    // ****************************************
    // Frame engine states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE = 3'h4
    } pwc_state_e;

endpackage

// >>> rtl/pwc_dec_if.sv
// Carries one frame's control code to the decoder and its decision back.
// Assumes the decoder is purely combinational.
`timescale 1ns/100ps
`default_nettype none

interface pwc_dec_if #(parameter int STEP_W = 16);
    logic [1:0] ctrl_bits;
    logic [1:0] pins;
    logic signed [STEP_W-1:0] step;
    logic later;
    logic earlier;
    logic sec_req;
    logic signed [STEP_W:0] adj;

    modport dec(input ctrl_bits, pins, step, output later, earlier, sec_req, adj);
    modport user(output ctrl_bits, pins, step, input later, earlier, sec_req, adj);
endinterface

`default_nettype wire

// >>> rtl/pwc_decode.sv
// Decodes control bits and host pins into a phase shift or a secondary request.
// Assumes inputs are stable while the frame engine reads the decision.
`timescale 1ns/100ps
`default_nettype none

module pwc_decode
    import pwc_pkg::*;
(
    // Decision channel
    pwc_dec_if.dec dif
);

    logic signed [$bits(dif.adj)-1:0] s_ext;

    always_comb begin
        s_ext = {dif.step[$bits(dif.step)-1], dif.step};
        dif.later = 1'b0;
        dif.earlier = 1'b0;
        dif.sec_req = 1'b0;
        case ({dif.ctrl_bits, dif.pins})
            4'h1: dif.later = 1'b1;
            4'h2: dif.earlier = 1'b1;
            4'h3: dif.sec_req = 1'b1;
            4'h4: dif.later = 1'b1;
            4'h8: dif.earlier = 1'b1;
            4'hC: dif.sec_req = 1'b1;
            default: ;
        endcase
        // Sign of the step reverses direction by itself
        if (dif.later) begin
            dif.adj = s_ext;
        end else if (dif.earlier) begin
            dif.adj = -s_ext;
        end else begin
            dif.adj = '0;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/pwc_word_ctrl.sv
// Primary serial word engine with phase control and secondary sync request.
// Assumes an APB master on clk_i and a host serial port on asynchronous pins.
//
// Notes on behaviour
// - On frame sync fall, take 14 DAC bits, send all 16 ADC bits.
// - Bits 00, pins 01: next sample later by step clocks at sync rise; the code applies the shift at the next internal sync fall.
// - In that case a negative step moves the internal sync earlier.
// - Bits 00, pins 10: sample earlier by step; negative step means later.
// - Bits 00, pins 11: request a secondary frame sync.
// - Secondary sync comes half a sample period after primary sync fall.
// - Bits 01, pins 00: sample later by step; negative step means earlier.
// - Bits 10, pins 00: sample earlier by step; negative step means later.
// - Bits 11, pins 00: request a secondary frame sync.
// - Any other code: no shift, no secondary request.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module pwc_word_ctrl
    import pwc_pkg::*;
#(
    parameter int STEP_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Host serial link
    input wire logic sclk_i,
    input wire logic frame_sync_n_i,
    input wire logic sdin_i,
    output logic sdout_o,
    input wire logic host_ctrl_pin_lo_i,
    input wire logic host_ctrl_pin_hi_i,
    // Converter side
    output logic int_fs_n_o,
    output logic sec_fs_n_o,
    output logic [13:0] dac_word_o,
    output logic dac_valid_o
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (STEP_W < 2 || STEP_W > 16) begin : g_chk
        $error("STEP_W must lie in 2..16");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0] fs_s;
        logic [2:0] sck_s;
        logic [1:0] din_s;
        logic [1:0] plo_s;
        logic [1:0] phi_s;
        pwc_state_e st;
        logic [4:0] bit_cnt;
        logic [15:0] tx;
        logic [15:0] rx;
        logic sdout;
        logic [1:0] pins;
        logic [1:0] ctrl;
        logic [13:0] dac;
        logic done;
        logic last_later;
        logic last_earlier;
        logic last_sec;
        logic en;
        logic signed [STEP_W-1:0] step;
        logic [15:0] period;
        logic [15:0] adc;
        logic signed [STEP_W:0] adj_pend;
        logic [15:0] phase_cnt;
        logic int_fs_n;
        logic [15:0] half_cnt;
        logic sec_pend;
        logic sec_fs_n;
        logic [31:0] prdata;
    } pwc_st_s;

    pwc_st_s q;
    pwc_st_s d;

    logic fs_fall;
    logic sck_rise;
    logic sck_fall;
    logic apb_wr;
    logic signed [STEP_W:0] step_ext;

    pwc_dec_if #(.STEP_W(STEP_W)) dif ();

    pwc_decode u_dec (
        .dif(dif)
    );

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == OFS_CTRL) || (a == OFS_STEP) || (a == OFS_PERIOD) ||
                   (a == OFS_ADC) || (a == OFS_DAC) || (a == OFS_STAT);
    endfunction

    function automatic logic [15:0] next_period(input logic [15:0] p,
                                                input logic signed [STEP_W:0] a);
        logic signed [18:0] t;
        t = $signed({3'b000, p}) + 19'(a) - 19'sd1;
        if (t < 19'sd1) begin
            next_period = 16'h0001;
        end else if (t > 19'sd65535) begin
            next_period = 16'hFFFF;
        end else begin
            next_period = t[15:0];
        end
    endfunction

    // ****************************************
    // Edges and bus strobes
    // ****************************************
    assign fs_fall = q.fs_s[2] & ~q.fs_s[1];
    assign sck_rise = ~q.sck_s[2] & q.sck_s[1];
    assign sck_fall = q.sck_s[2] & ~q.sck_s[1];
    assign apb_wr = psel_i & penable_i & pwrite_i & addr_hit(paddr_i);
    assign step_ext = {q.step[STEP_W-1], q.step};

    assign dif.ctrl_bits = q.rx[1:0];
    assign dif.pins = q.pins;
    assign dif.step = q.step;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.sec_fs_n = 1'b1;
        d.fs_s = {q.fs_s[1:0], frame_sync_n_i};
        d.sck_s = {q.sck_s[1:0], sclk_i};
        d.din_s = {q.din_s[0], sdin_i};
        d.plo_s = {q.plo_s[0], host_ctrl_pin_lo_i};
        d.phi_s = {q.phi_s[0], host_ctrl_pin_hi_i};

        // Register writes
        if (apb_wr) begin
            case (paddr_i)
                OFS_CTRL: d.en = pwdata_i[0];
                OFS_STEP: d.step = pwdata_i[STEP_W-1:0];
                OFS_PERIOD: d.period = pwdata_i[15:0];
                OFS_ADC: d.adc = pwdata_i[15:0];
                default: ;
            endcase
        end

        // Register reads, captured in the setup phase
        if (psel_i & ~penable_i) begin
            case (paddr_i)
                OFS_CTRL: d.prdata = {31'h0, q.en};
                OFS_STEP: d.prdata = {{(32 - STEP_W){q.step[STEP_W-1]}}, q.step};
                OFS_PERIOD: d.prdata = {16'h0, q.period};
                OFS_ADC: d.prdata = {16'h0, q.adc};
                OFS_DAC: d.prdata = {18'h0, q.dac};
                OFS_STAT: d.prdata = {24'h0, q.st != ST_IDLE, q.last_sec,
                                      q.last_earlier, q.last_later, q.pins, q.ctrl};
                default: d.prdata = 32'h0;
            endcase
        end

        // Internal sampling sync; pending shift applies at its fall
        if (!q.en) begin
            d.int_fs_n = 1'b1;
            d.phase_cnt = q.period;
        end else if (q.phase_cnt == 16'h0) begin
            d.int_fs_n = 1'b0;
            d.phase_cnt = next_period(q.period, q.adj_pend);
            d.adj_pend = '0;
        end else begin
            d.int_fs_n = 1'b1;
            d.phase_cnt = q.phase_cnt - 16'h1;
        end

        // Secondary sync timer from primary sync fall
        if (q.half_cnt != 16'h0) begin
            d.half_cnt = q.half_cnt - 16'h1;
            if (q.half_cnt == 16'h1 && q.sec_pend) begin
                d.sec_fs_n = 1'b0;
                d.sec_pend = 1'b0;
            end
        end

        // Frame engine
        if (fs_fall && q.st != ST_DONE) begin
            d.st = ST_SHIFT;
            d.bit_cnt = BIT_CNT_INIT;
            d.tx = q.adc;
            d.sdout = q.adc[FRAME_BITS-1];
            d.pins = {q.phi_s[1], q.plo_s[1]};
            d.half_cnt = (q.period[15:1] == 15'h0) ? 16'h0001 : {1'b0, q.period[15:1]};
            d.sec_pend = 1'b0;
        end else begin
            case (q.st)
                ST_IDLE: ;
                ST_SHIFT: begin
                    if (sck_fall) begin
                        d.rx = {q.rx[14:0], q.din_s[1]};
                        d.tx = {q.tx[14:0], 1'b0};
                        d.bit_cnt = q.bit_cnt - 5'h1;
                        if (q.bit_cnt == 5'h1) begin
                            d.st = ST_DONE;
                        end
                    end else if (sck_rise) begin
                        d.sdout = q.tx[FRAME_BITS-1];
                    end
                end
                ST_DONE: begin
                    d.dac = q.rx[FRAME_BITS-1:DAC_LSB];
                    d.ctrl = q.rx[1:0];
                    d.done = 1'b1;
                    d.last_later = dif.later;
                    d.last_earlier = dif.earlier;
                    d.last_sec = dif.sec_req;
                    if (dif.later || dif.earlier) begin
                        d.adj_pend = dif.adj;
                    end
                    if (dif.sec_req) begin
                        d.sec_pend = 1'b1;
                    end
                    d.st = ST_IDLE;
                end
                default: d.st = ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.fs_s <= 3'h7;
            q.sck_s <= 3'h7;
            q.st <= ST_IDLE;
            q.sdout <= 1'b0;
            q.en <= RST_EN;
            q.period <= RST_PERIOD;
            q.adc <= RST_ADC;
            q.int_fs_n <= 1'b1;
            q.sec_fs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata_o = q.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_hit(paddr_i);
    assign sdout_o = q.sdout;
    assign int_fs_n_o = q.int_fs_n;
    assign sec_fs_n_o = q.sec_fs_n;
    assign dac_word_o = q.dac;
    assign dac_valid_o = q.done;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_frame_start_load: assert property (
        fs_fall && q.st != ST_DONE |=> q.st == ST_SHIFT && q.bit_cnt == BIT_CNT_INIT
            && q.sdout == $past(q.adc[15]))
        else $error("frame start did not load the ADC word");

    a_dac_word_capture: assert property (
        q.st == ST_DONE |=> q.dac == $past(q.rx[15:2]) && dac_valid_o ##1 !dac_valid_o)
        else $error("DAC word not captured from the frame");

    a_pins_later_step: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b00 && q.pins == 2'b01
            |=> q.adj_pend == $past(step_ext) && q.last_later)
        else $error("pin request for later sampling not taken");

    a_neg_step_earlier: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b00 && q.pins == 2'b01 && q.step[STEP_W-1]
            |=> $signed(q.adj_pend) < 0)
        else $error("negative step did not move sync earlier");

    a_pins_earlier_step: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b00 && q.pins == 2'b10
            |=> q.adj_pend == -$past(step_ext) && q.last_earlier)
        else $error("pin request for earlier sampling not taken");

    a_pins_sec_req: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b00 && q.pins == 2'b11 |=> q.sec_pend)
        else $error("pin secondary request lost");

    a_sec_half_period: assert property (
        $fell(sec_fs_n_o) |-> $past(q.half_cnt) == 16'h0001 && $past(q.sec_pend)
            ##1 sec_fs_n_o)
        else $error("secondary sync not at half period");

    a_bits_later_step: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b01 && q.pins == 2'b00
            |=> q.adj_pend == $past(step_ext))
        else $error("bit request for later sampling not taken");

    a_bits_earlier_step: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b10 && q.pins == 2'b00
            |=> q.adj_pend == -$past(step_ext))
        else $error("bit request for earlier sampling not taken");

    a_bits_sec_req: assert property (
        q.st == ST_DONE && q.rx[1:0] == 2'b11 && q.pins == 2'b00 |=> q.sec_pend)
        else $error("bit secondary request lost");

    a_other_code_none: assert property (
        q.st == ST_DONE && !({q.rx[1:0], q.pins} inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC})
            |=> !q.last_later && !q.last_earlier && !q.last_sec && !q.sec_pend)
        else $error("unlisted code caused an action");

    a_reload_signed: assert property (
        q.en && q.phase_cnt == 16'h0
            |=> !int_fs_n_o && q.phase_cnt == next_period($past(q.period), $past(q.adj_pend)))
        else $error("sampling period reload wrong");

endmodule

`default_nettype wire

// >>> tb/pwc_host_model.sv
// Host serial port model: frame sync, shift clock, data and control pins.
// Assumes the caller runs one frame at a time; the shift clock idles high.
`timescale 1ns/100ps
`default_nettype none

module pwc_host_model (
    // Serial link
    output logic sclk_o,
    output logic frame_sync_n_o,
    output logic sdin_o,
    input wire logic sdout_i,
    // Control pins
    output logic pin_lo_o,
    output logic pin_hi_o
);
    logic [15:0] rx_word;

    initial begin
        sclk_o = 1'b1;
        frame_sync_n_o = 1'b1;
        sdin_o = 1'b0;
        pin_lo_o = 1'b0;
        pin_hi_o = 1'b0;
        rx_word = 16'h0000;
    end

    // ****************************************
    // One primary frame, MSB first, 80 ns shift clock
    // ****************************************
    task automatic frame(input logic [15:0] word, input logic [1:0] pins);
        {pin_hi_o, pin_lo_o} = pins;
        sdin_o = word[15];
        #40;
        frame_sync_n_o = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            rx_word[i] = sdout_i;
            #40;
            sclk_o = 1'b1;
            frame_sync_n_o = 1'b1;
            sdin_o = (i > 0) ? word[(i + 15) % 16] : ~word[0];
            #40;
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/tb_primary_word_control_decoder.sv
// Self-checking bench for the primary word control decoder.
// Assumes the host model drives the link and the bench is the APB master.
`timescale 1ns/100ps
`default_nettype none

module tb_primary_word_control_decoder;
    import pwc_pkg::*;
    logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sclk, fs_n, sdin, sdout, pin_lo, pin_hi, int_fs_n, sec_fs_n, dac_valid;
    logic [13:0] dac_word;
    logic fs_d = 1'b1;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0, n_int = 0, n_sec = 0, n_dv = 0, int_prev = 0, int_last = 0, sec_at = 0;
    int fall_at = 0;
    // Rows: {secondary, earlier, later, pin hi, pin lo, bit hi, bit lo}
    logic [6:0] rows [10] = '{7'h00, 7'h14, 7'h28, 7'h4C, 7'h11, 7'h22, 7'h43, 7'h05,
                              7'h0F, 7'h06};
    logic [6:0] shifts [4] = '{7'h14, 7'h28, 7'h11, 7'h22};
    logic signed [15:0] steps [4] = '{16'sh0005, 16'sh0005, 16'shFFFB, 16'shFFFB};
    logic [7:0] ofs [4] = '{OFS_CTRL, OFS_STEP, OFS_PERIOD, OFS_ADC};

    pwc_word_ctrl #(.STEP_W(16)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sclk_i(sclk),
        .frame_sync_n_i(fs_n), .sdin_i(sdin), .sdout_o(sdout),
        .host_ctrl_pin_lo_i(pin_lo), .host_ctrl_pin_hi_i(pin_hi), .int_fs_n_o(int_fs_n),
        .sec_fs_n_o(sec_fs_n), .dac_word_o(dac_word), .dac_valid_o(dac_valid));
    pwc_host_model host (.sclk_o(sclk), .frame_sync_n_o(fs_n), .sdin_o(sdin),
        .sdout_i(sdout), .pin_lo_o(pin_lo), .pin_hi_o(pin_hi));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ****************************************
    // Monitors and shared tasks
    // ****************************************
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        fs_d <= fs_n;
        if (fs_d && !fs_n) fall_at <= cyc;
        if (dac_valid === 1'b1) n_dv <= n_dv + 1;
        if (sec_fs_n === 1'b0) begin
            n_sec <= n_sec + 1;
            sec_at <= cyc;
        end
        if (int_fs_n === 1'b0) begin
            n_int <= n_int + 1;
            int_prev <= int_last;
            int_last <= cyc;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_int;
        int n0;
        int k;
        n0 = n_int;
        k = 0;
        while (n_int == n0 && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        if (k == 200) errors++;
    endtask

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #500000;
        errors++;
        final_report();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [15:0] adc;
        logic [15:0] word;
        int n0, d0, half, expd, k;
        nrst_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge clk_i);
        check("idle outputs", 32'h0000_000C, {28'h0, int_fs_n, sec_fs_n, dac_valid, sdout});
        nrst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ofs[i], 32'h0000_0000);
            check("reset value", (i == 2) ? {16'h0000, RST_PERIOD} : 32'h0000_0000, rd);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("unmapped read", 32'h0000_0001, {31'h0, err});
        apb(1'b1, OFS_DAC, 32'h0000_3FFF);
        apb(1'b0, OFS_DAC, 32'h0000_0000);
        check("read-only dac", 32'h0000_0000, rd);
        $display("register test done");
        half = RST_PERIOD / 2;
        for (int i = 0; i < 10; i++) begin
            adc = 16'hA5C3 ^ 16'(i * 16'h1111);
            word = {14'h1A5 + 14'(i), rows[i][1:0]};
            apb(1'b1, OFS_ADC, {16'h0000, adc});
            n0 = n_sec;
            d0 = n_dv;
            host.frame(word, rows[i][3:2]);
            repeat (600) @(posedge clk_i);
            check("dac word", {18'h0, word[15:2]}, {18'h0, dac_word});
            check("adc word", {16'h0, adc}, {16'h0, host.rx_word});
            check("dac pulses", 32'h0000_0001, 32'(n_dv - d0));
            check("sec count", {31'h0, rows[i][6]}, 32'(n_sec - n0));
            if (rows[i][6])
                check("sec delay", 32'h1, {31'h0, sec_at - fall_at inside {[half - 1:half + 6]}});
            apb(1'b0, OFS_STAT, 32'h0000_0000);
            check("status", {25'h0, rows[i]}, rd);
            $display("decode row %0d done", i);
        end
        apb(1'b1, OFS_PERIOD, 32'h0000_0028);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_STEP, 32'(steps[i]));
            apb(1'b0, OFS_STEP, 32'h0000_0000);
            check("step readback", 32'(steps[i]), rd);
            d0 = n_dv;
            host.frame({14'h0000, shifts[i][1:0]}, shifts[i][3:2]);
            k = 0;
            while (n_dv == d0 && k < 400) begin
                @(posedge clk_i);
                k++;
            end
            if (k == 400) errors++;
            expd = 40 + (shifts[i][4] ? int'(steps[i]) : -int'(steps[i]));
            wait_int();
            wait_int();
            check("shifted period", 32'(expd), 32'(int_last - int_prev));
            wait_int();
            check("plain period", 32'h0000_0028, 32'(int_last - int_prev));
            $display("shift case %0d done", i);
        end
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("sync in reset", 32'h0000_0001, {31'h0, int_fs_n});
        nrst_i <= 1'b1;
        apb(1'b0, OFS_PERIOD, 32'h0000_0000);
        check("period after reset", {16'h0000, RST_PERIOD}, rd);
        $display("second reset done");
        final_report();
    end
endmodule

`default_nettype wire
